// >>> design/ebt_pin_sync.sv
/*
  Three-flop synchroniser and edge detector for the external count pin.
  Assumes the pin is asynchronous to i_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module ebt_pin_sync (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Pin and edges
  input wire logic i_pin,
  ebt_sync_if.src o_edge
);
  logic [2:0] sync_r;
  logic [2:0] sync_nxt;
  logic level_r;
  logic level_nxt;

  // Shift chain, level taken when stages two and three agree
  always_comb begin
    sync_nxt = {sync_r[1:0], i_pin};
    level_nxt = (sync_r[2] == sync_r[1]) ? sync_r[1] : level_r;
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sync_r <= 3'h0;
      level_r <= 1'b0;
    end else begin
      sync_r <= sync_nxt;
      level_r <= level_nxt;
    end
  end

  // Edges of the filtered level
  assign o_edge.rise = level_nxt & ~level_r;
  assign o_edge.fall = ~level_nxt & level_r;
endmodule
`default_nettype wire

// >>> design/ebt_timer.sv
/*
  8-bit timer/counter with one double-buffered compare unit, prescaler,
  external count input, force-compare and overflow/compare flags.
  Control bits are plain ports; CPU strobes are one-cycle pulses on i_clk.
*/
// Operation
// - Counter and compare value are 8 bits; counter counts up or down.
// - Timer clock comes from prescaler or external count pin per clock select.
// - Clock select zero stops counting; a CPU counter write still loads the counter.
// - CPU may read and write the counter at any time.
// - CPU counter write beats clear, increment or decrement.
// - Waveform mode picks clear, increment or decrement per timer clock.
// - Bottom flags 0x00 and max flags 0xff for the waveform logic.
// - Top is 0xff or the compare value depending on mode.
// - Overflow flag set per mode and usable as interrupt source.
// - Comparator match sets compare flag on the following timer clock.
// - Compare flag, enable and global enable raise compare interrupt.
// - Compare flag clears on service or by writing one.
// - Output derived from match, waveform mode and output mode.
// - Compare buffered in PWM modes, direct in normal and clear-on-match.
// - Buffered compare loads only at top (0xff), in both PWM modes.
// - CPU compare access hits buffer when buffered, else active.
// - Force strobe in non-PWM modes forces a match onto output.
// - Forced match sets no flag and leaves the counter alone.
// - Counter write blocks compare match in next timer clock.
// - Each request has its own flag and enable, both gated by the global enable.
// - Normal mode counts up, wraps, sets overflow when becoming zero.
// - Clear-on-match mode clears counter at compare match.
// - Fast PWM counts bottom to max, output acts at match and bottom.
// - Output mode changes act immediately, not buffered.
`timescale 1ns/1ps
`default_nettype none
module ebt_timer (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Control fields
  input wire logic [2:0] i_clock_select,
  input wire logic [1:0] i_waveform_mode,
  input wire logic [1:0] i_compare_output_mode,
  input wire logic i_force_compare_strobe,
  // CPU counter access
  input wire logic i_counter_wr,
  input wire logic [7:0] i_counter_wdata,
  output logic [7:0] o_counter_value,
  // CPU compare access
  input wire logic i_compare_wr,
  input wire logic [7:0] i_compare_wdata,
  output logic [7:0] o_compare_value,
  output logic [7:0] o_compare_active,
  // Flags, mask and interrupts
  input wire logic i_global_irq_enable,
  input wire logic i_overflow_irq_enable,
  input wire logic i_compare_irq_enable,
  input wire logic i_overflow_clear,
  input wire logic i_compare_clear,
  input wire logic i_overflow_serviced,
  input wire logic i_compare_serviced,
  output logic o_overflow_flag,
  output logic o_compare_flag,
  output logic o_overflow_irq,
  output logic o_compare_irq,
  // Status to waveform and outside
  output logic o_bottom,
  output logic o_max,
  output logic o_match,
  // Pins
  input wire logic i_external_count_pin,
  output logic o_compare_output
);
  ebt_sync_if pin_edge ();

  logic [9:0] presc_r;
  logic [9:0] presc_nxt;
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic [7:0] ocr_r;
  logic [7:0] ocr_nxt;
  logic [7:0] ocr_buf_r;
  logic [7:0] ocr_buf_nxt;
  logic dir_down_r;
  logic dir_down_nxt;
  logic block_r;
  logic block_nxt;
  logic match_pend_r;
  logic match_pend_nxt;
  logic ov_r;
  logic ov_nxt;
  logic cf_r;
  logic cf_nxt;
  logic oc_r;
  logic oc_nxt;
  logic tick;
  logic pwm_mode;
  logic raw_match;
  logic eff_match;
  logic [7:0] top_val;

  ebt_pin_sync u_sync (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_pin(i_external_count_pin),
    .o_edge(pin_edge)
  );

  // Free-running prescaler
  always_comb begin
    presc_nxt = presc_r + 10'h001;
  end

  always_comb begin
    case (i_clock_select)
      ebt_pkg::CS_STOP: tick = 1'b0;
      ebt_pkg::CS_DIV1: tick = 1'b1;
      ebt_pkg::CS_DIV8: tick = (presc_r[2:0] == 3'h7);
      ebt_pkg::CS_DIV64: tick = (presc_r[5:0] == 6'h3f);
      ebt_pkg::CS_DIV256: tick = (presc_r[7:0] == 8'hff);
      ebt_pkg::CS_DIV1024: tick = (presc_r == 10'h3ff);
      ebt_pkg::CS_EXT_FALL: tick = pin_edge.fall;
      ebt_pkg::CS_EXT_RISE: tick = pin_edge.rise;
      default: tick = 1'b0;
    endcase
  end

  assign o_bottom = (cnt_r == ebt_pkg::BOTTOM_VAL);
  assign o_max = (cnt_r == ebt_pkg::MAX_VAL);
  assign pwm_mode = (i_waveform_mode == ebt_pkg::WGM_PHASE) || (i_waveform_mode == ebt_pkg::WGM_FAST);
  assign top_val = (i_waveform_mode == ebt_pkg::WGM_CTC) ? ocr_r : ebt_pkg::MAX_VAL;
  assign raw_match = (cnt_r == ocr_r);
  assign eff_match = raw_match & ~block_r;
  assign o_match = eff_match;

  // Counter, direction and compare registers
  always_comb begin
    cnt_nxt = cnt_r;
    dir_down_nxt = dir_down_r;
    ocr_nxt = ocr_r;
    ocr_buf_nxt = ocr_buf_r;
    block_nxt = block_r;
    if (tick) begin
      block_nxt = 1'b0;
      case (i_waveform_mode)
        ebt_pkg::WGM_NORMAL: cnt_nxt = cnt_r + 8'h01;
        ebt_pkg::WGM_CTC: cnt_nxt = (cnt_r == top_val) ? ebt_pkg::BOTTOM_VAL : cnt_r + 8'h01;
        ebt_pkg::WGM_FAST: cnt_nxt = cnt_r + 8'h01;
        ebt_pkg::WGM_PHASE: begin
          if (o_max) begin
            dir_down_nxt = 1'b1;
            cnt_nxt = cnt_r - 8'h01;
          end else if (o_bottom && dir_down_r) begin
            dir_down_nxt = 1'b0;
            cnt_nxt = cnt_r + 8'h01;
          end else if (dir_down_r) begin
            cnt_nxt = cnt_r - 8'h01;
          end else begin
            cnt_nxt = cnt_r + 8'h01;
          end
        end
        default: cnt_nxt = cnt_r;
      endcase
      // buffered load at top (max) in both PWM modes
      if ((i_waveform_mode == ebt_pkg::WGM_PHASE && o_max) || (i_waveform_mode == ebt_pkg::WGM_FAST && o_max)) begin
        ocr_nxt = ocr_buf_r;
      end
    end
    if (!pwm_mode) begin
      dir_down_nxt = 1'b0;
    end
    if (i_counter_wr) begin
      cnt_nxt = i_counter_wdata;
      block_nxt = 1'b1;
    end
    if (i_compare_wr) begin
      ocr_buf_nxt = i_compare_wdata;
      if (!pwm_mode) begin
        ocr_nxt = i_compare_wdata;
      end
    end
  end

  // Flags and compare output
  always_comb begin
    ov_nxt = ov_r;
    cf_nxt = cf_r;
    oc_nxt = oc_r;
    match_pend_nxt = match_pend_r;
    if (i_compare_clear || i_compare_serviced) begin
      cf_nxt = 1'b0;
    end
    if (i_overflow_clear || i_overflow_serviced) begin
      ov_nxt = 1'b0;
    end
    if (tick) begin
      match_pend_nxt = eff_match;
      if (match_pend_r) begin
        cf_nxt = 1'b1;
      end
      if (i_waveform_mode == ebt_pkg::WGM_PHASE) begin
        if (o_bottom && dir_down_r) begin
          ov_nxt = 1'b1;
        end
      end else if (o_max) begin
        ov_nxt = 1'b1;
      end
      case (i_waveform_mode)
        ebt_pkg::WGM_FAST: begin
          if (eff_match && i_compare_output_mode[1]) begin
            oc_nxt = i_compare_output_mode[0];
          end else if (o_max && i_compare_output_mode[1]) begin
            oc_nxt = ~i_compare_output_mode[0];
          end
        end
        ebt_pkg::WGM_PHASE: begin
          if (eff_match && i_compare_output_mode[1]) begin
            oc_nxt = dir_down_r ^ ~i_compare_output_mode[0];
          end
        end
        default: begin
          if (eff_match) begin
            case (i_compare_output_mode)
              ebt_pkg::COM_TOGGLE: oc_nxt = ~oc_r;
              ebt_pkg::COM_CLEAR: oc_nxt = 1'b0;
              ebt_pkg::COM_SET: oc_nxt = 1'b1;
              default: oc_nxt = oc_r;
            endcase
          end
        end
      endcase
    end
    if (i_force_compare_strobe && !pwm_mode) begin
      case (i_compare_output_mode)
        ebt_pkg::COM_TOGGLE: oc_nxt = ~oc_r;
        ebt_pkg::COM_CLEAR: oc_nxt = 1'b0;
        ebt_pkg::COM_SET: oc_nxt = 1'b1;
        default: oc_nxt = oc_r;
      endcase
    end
    if (i_counter_wr) begin
      match_pend_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      presc_r <= ebt_pkg::PRESC_RST;
      cnt_r <= ebt_pkg::CNT_RST;
      ocr_r <= ebt_pkg::CMP_RST;
      ocr_buf_r <= ebt_pkg::CMP_RST;
      dir_down_r <= 1'b0;
      block_r <= 1'b0;
      match_pend_r <= 1'b0;
      ov_r <= 1'b0;
      cf_r <= 1'b0;
      oc_r <= 1'b0;
    end else begin
      presc_r <= presc_nxt;
      cnt_r <= cnt_nxt;
      ocr_r <= ocr_nxt;
      ocr_buf_r <= ocr_buf_nxt;
      dir_down_r <= dir_down_nxt;
      block_r <= block_nxt;
      match_pend_r <= match_pend_nxt;
      ov_r <= ov_nxt;
      cf_r <= cf_nxt;
      oc_r <= oc_nxt;
    end
  end

  assign o_counter_value = cnt_r;
  assign o_compare_value = pwm_mode ? ocr_buf_r : ocr_r;
  assign o_compare_active = ocr_r;
  assign o_overflow_flag = ov_r;
  assign o_compare_flag = cf_r;
  assign o_overflow_irq = ov_r & i_overflow_irq_enable & i_global_irq_enable;
  assign o_compare_irq = cf_r & i_compare_irq_enable & i_global_irq_enable;
  assign o_compare_output = oc_r;
endmodule
`default_nettype wire

// >>> dv/ebt_pin_model.sv
/*
  Far-side model of the external count pin: a burst of pulses per start.
  Assumes the bench clock; pin idles low between bursts.
*/
`timescale 1ns/1ps
`default_nettype none
module ebt_pin_model #(
  parameter int PULSES = 3
) (
  input wire logic i_clk,
  input wire logic i_start,
  output logic o_pin
);
  initial o_pin = 1'b0;
  // Slow pulses, four cycles high and four low
  always begin
    @(posedge i_start);
    repeat (PULSES) begin
      repeat (4) @(negedge i_clk);
      o_pin = 1'b1;
      repeat (4) @(negedge i_clk);
      o_pin = 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> dv/ebt_timer_asserts.sv
/*
  Concurrent checks on the timer ports.
  Assumes a bind onto ebt_timer and clock select 1 ticking every cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module ebt_timer_asserts (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [2:0] i_clock_select,
  input wire logic [1:0] i_waveform_mode,
  input wire logic [1:0] i_compare_output_mode,
  input wire logic i_force_compare_strobe,
  input wire logic i_counter_wr,
  input wire logic [7:0] i_counter_wdata,
  input wire logic [7:0] o_counter_value,
  input wire logic i_compare_wr,
  input wire logic [7:0] i_compare_wdata,
  input wire logic [7:0] o_compare_active,
  input wire logic i_global_irq_enable,
  input wire logic i_compare_irq_enable,
  input wire logic o_compare_flag,
  input wire logic o_compare_irq,
  input wire logic o_overflow_flag,
  input wire logic o_bottom,
  input wire logic o_max,
  input wire logic o_compare_output
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  a_stop_hold: assert property (i_clock_select == 3'h0 && !i_counter_wr |=> $stable(o_counter_value))
    else $error("counter moved while stopped");
  a_write_wins: assert property (i_counter_wr |=> o_counter_value == $past(i_counter_wdata))
    else $error("counter write lost");
  a_bottom_flag: assert property (o_bottom == (o_counter_value == ebt_pkg::BOTTOM_VAL))
    else $error("bottom flag wrong");
  a_max_flag: assert property (o_max == (o_counter_value == ebt_pkg::MAX_VAL))
    else $error("max flag wrong");
  a_normal_step: assert property (i_clock_select == ebt_pkg::CS_DIV1
    && i_waveform_mode == ebt_pkg::WGM_NORMAL
    && !i_counter_wr |=> o_counter_value == $past(o_counter_value) + 8'h01)
    else $error("normal count step wrong");
  a_ovf_set: assert property (i_clock_select == ebt_pkg::CS_DIV1
    && i_waveform_mode == ebt_pkg::WGM_NORMAL
    && !i_counter_wr && o_counter_value == 8'hff |=> o_overflow_flag)
    else $error("overflow not set on wrap");
  a_cmp_irq: assert property (o_compare_irq == (o_compare_flag && i_compare_irq_enable && i_global_irq_enable))
    else $error("compare request gating wrong");
  a_direct_cmp: assert property (i_compare_wr && !i_waveform_mode[0] |=> o_compare_active == $past(i_compare_wdata))
    else $error("direct compare write lost");
  a_force_toggle: assert property (i_force_compare_strobe && i_clock_select == 3'h0
    && i_waveform_mode == ebt_pkg::WGM_NORMAL && i_compare_output_mode == ebt_pkg::COM_TOGGLE
    |=> o_compare_output != $past(o_compare_output))
    else $error("forced toggle missing");
  a_force_noflag: assert property (i_force_compare_strobe && i_clock_select == 3'h0
    && !o_compare_flag |=> !o_compare_flag)
    else $error("forced match set the flag");
endmodule
bind ebt_timer ebt_timer_asserts u_chk (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_clock_select(i_clock_select), .i_waveform_mode(i_waveform_mode),
  .i_compare_output_mode(i_compare_output_mode), .i_force_compare_strobe(i_force_compare_strobe),
  .i_counter_wr(i_counter_wr), .i_counter_wdata(i_counter_wdata), .o_counter_value(o_counter_value),
  .i_compare_wr(i_compare_wr), .i_compare_wdata(i_compare_wdata), .o_compare_active(o_compare_active),
  .i_global_irq_enable(i_global_irq_enable), .i_compare_irq_enable(i_compare_irq_enable),
  .o_compare_flag(o_compare_flag), .o_compare_irq(o_compare_irq), .o_overflow_flag(o_overflow_flag),
  .o_bottom(o_bottom), .o_max(o_max), .o_compare_output(o_compare_output)
);
`default_nettype wire

// >>> dv/ebt_timer_tb.sv
/*
  Self-checking bench for the timer: force table, then hand tests.
  Assumes clock select 1 gives a tick on every clock.
*/
`timescale 1ns/1ps
`default_nettype none
module ebt_timer_tb;
  typedef struct {logic [1:0] wgm; logic [1:0] com; logic oc;} ebt_row_s;
  logic clk = 0, rstn = 0, foc = 0, cwr = 0, mwr = 0, gie = 0, oie = 0, cie = 0;
  logic oclr = 0, cclr = 0, osrv = 0, csrv = 0, start = 0, pin;
  logic [2:0] cs = 0;
  logic [1:0] wgm = 0, com = 0;
  logic [7:0] cdat = 0, mdat = 0, cnt, cval, cact;
  logic oflag, cflag, oirq, cirq, bot, mx, mt, oc;
  int miscompares = 0, checked = 0;
  ebt_row_s rows [8] = '{'{0,3,1}, '{0,2,0}, '{0,1,1}, '{0,1,0}, '{0,0,0}, '{0,3,1}, '{3,2,1}, '{2,1,0}};
  // Prescaler divide ratios for clock select codes 2 to 5
  int divs [4] = '{8, 64, 256, 1024};
  always #12.5 clk = ~clk;
  ebt_timer dut (.i_clk(clk), .i_resetn(rstn), .i_clock_select(cs), .i_waveform_mode(wgm),
    .i_compare_output_mode(com), .i_force_compare_strobe(foc), .i_counter_wr(cwr), .i_counter_wdata(cdat),
    .o_counter_value(cnt), .i_compare_wr(mwr), .i_compare_wdata(mdat), .o_compare_value(cval),
    .o_compare_active(cact), .i_global_irq_enable(gie), .i_overflow_irq_enable(oie),
    .i_compare_irq_enable(cie), .i_overflow_clear(oclr), .i_compare_clear(cclr),
    .i_overflow_serviced(osrv), .i_compare_serviced(csrv), .o_overflow_flag(oflag),
    .o_compare_flag(cflag), .o_overflow_irq(oirq), .o_compare_irq(cirq), .o_bottom(bot), .o_max(mx),
    .o_match(mt), .i_external_count_pin(pin), .o_compare_output(oc));
  ebt_pin_model u_pin (.i_clk(clk), .i_start(start), .o_pin(pin));
  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr_cnt(input logic [7:0] v);
    cwr = 1; cdat = v; step(1); cwr = 0;
  endtask
  task automatic wr_cmp(input logic [7:0] v);
    mwr = 1; mdat = v; step(1); mwr = 0;
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    #400000;
    miscompares++;
    test_done;
  end
  // Main sequence
  initial begin
    step(2); rstn = 1; step(1);
    chk(cnt, 0); chk(cact, 0); chk(oc, 0); chk(bot, 1);
    foreach (rows[i]) begin
      wgm = rows[i].wgm; com = rows[i].com; foc = 1; step(1); foc = 0;
      chk(oc, rows[i].oc);
      chk({cflag, cnt}, 0);
    end
    wgm = 0; wr_cnt(8'hfe); step(3); chk(cnt, 8'hfe);
    cs = 1; wr_cnt(8'hfe); step(1); chk(mx, 1);
    step(1); chk(cnt, 0); chk(oflag, 1);
    cs = 0; oie = 1; gie = 1; step(1); chk(oirq, 1);
    gie = 0; oclr = 1; step(1); oclr = 0; chk({oflag, oirq}, 0);
    wgm = 2; wr_cmp(8'h03); chk(cact, 3);
    cs = 1; wr_cnt(0); step(3); chk(cnt, 3); chk(mt, 1); step(1); chk(cnt, 0);
    step(1); chk(cflag, 1); cs = 0;
    cie = 1; gie = 1; step(1); chk(cirq, 1);
    cie = 0; csrv = 1; step(1); csrv = 0; chk({cflag, cirq}, 0);
    wgm = 0; wr_cmp(8'h05); cs = 1; wr_cnt(8'h05); chk(mt, 0); step(5); chk(cflag, 0);
    wr_cnt(8'h04); step(5); chk(cflag, 1); cs = 0; cclr = 1; step(1); cclr = 0;
    wgm = 3; com = 2'h2; wr_cmp(8'h40); chk(cval, 8'h40); chk(cact, 5);
    cs = 1; wr_cnt(8'hfe); step(2); chk(cact, 8'h40); chk(oc, 1);
    wr_cnt(8'h3f); step(2); chk(oc, 0); cs = 0;
    wgm = 2'h1; wr_cmp(8'h20); cs = 1; wr_cnt(8'hfe); step(2); chk(cact, 8'h20);
    step(1); chk(cnt, 8'hfd); oclr = 1; wr_cnt(8'h01); oclr = 0;
    step(2); chk({oflag, cnt}, 16'h0101); cs = 0; wgm = 0;
    foreach (divs[j]) begin
      cs = 0; wr_cnt(0); cs = 3'(j + 2); step(8 * divs[j]);
      chk(cnt, 16'h0008);
    end
    for (int k = 6; k < 8; k++) begin
      cs = 0; wr_cnt(0); cs = k[2:0]; start = 1; step(1); start = 0; step(40);
      chk(cnt, 3);
    end
    // Reset in mid-run with a set flag and a nonzero counter
    cs = 0; chk(oflag, 1); rstn = 0; step(1); rstn = 1; step(1);
    chk({oflag, oc, cnt}, 16'h0000); chk(cact, 16'h0000);
    test_done;
  end
endmodule
`default_nettype wire

// >>> include/ebt_pkg.sv
/*
  Package for the 8-bit timer with one compare unit: clock-select codes,
  waveform modes, extreme values and reset values.
  Assumes nothing of its surroundings.
*/
package ebt_pkg;
  localparam logic [7:0] BOTTOM_VAL = 8'h00;
  localparam logic [7:0] MAX_VAL = 8'hff;
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic [7:0] CMP_RST = 8'h00;
  // Clock-select codes
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam logic [9:0] PRESC_RST = 10'h000;
  // Waveform modes
  localparam logic [1:0] WGM_NORMAL = 2'h0;
  localparam logic [1:0] WGM_PHASE = 2'h1;
  localparam logic [1:0] WGM_CTC = 2'h2;
  localparam logic [1:0] WGM_FAST = 2'h3;
  // Compare output modes
  localparam logic [1:0] COM_NONE = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;
endpackage

// >>> include/ebt_sync_if.sv
/*
  Interface carrying the external count pin from the synchroniser to the
  counter core. Assumes one clock domain on the core side.
*/
`timescale 1ns/1ps
`default_nettype none
interface ebt_sync_if;
  logic rise;
  logic fall;
  modport src (output rise, output fall);
  modport dst (input rise, input fall);
endinterface
`default_nettype wire
